// file: shared/isaid_regs.svh
`ifndef ISAID_REGS_SVH
`define ISAID_REGS_SVH

// ----------------------------------------------------------------------------
// System-register encodings
// ----------------------------------------------------------------------------
`define ISAID_OP0          2'h3
`define ISAID_OP1          3'h0
`define ISAID_CRN          4'h0
`define ISAID_CRM          4'h6
`define ISAID_OP2_ATTR1    3'h1
`define ISAID_OP2_ATTR2    3'h2

// ----------------------------------------------------------------------------
// Exception class for a trapped system access
// ----------------------------------------------------------------------------
`define ISAID_EC_SYSACC    6'h18

// ----------------------------------------------------------------------------
// First register field positions (low bit) and values
// ----------------------------------------------------------------------------
`define ISAID_A1_WIDE_LS_LSB        60
`define ISAID_A1_WIDE_LS_VAL        4'h0
`define ISAID_A1_XSYNC_LSB          56
`define ISAID_A1_XSYNC_VAL          4'h1
`define ISAID_A1_INT8MM_LSB         52
`define ISAID_A1_INT8MM_VAL         4'h1
`define ISAID_A1_GHINT_LSB          48
`define ISAID_A1_GHINT_VAL          4'h1
`define ISAID_A1_BFLOAT_LSB         44
`define ISAID_A1_BFLOAT_VAL         4'h1
`define ISAID_A1_PRESTR_LSB         40
`define ISAID_A1_PRESTR_VAL         4'h1
`define ISAID_A1_SBAR_LSB           36
`define ISAID_A1_SBAR_VAL           4'h1
`define ISAID_A1_RINT_LSB           32
`define ISAID_A1_RINT_VAL           4'h1
`define ISAID_A1_GA_IMP_LSB         28
`define ISAID_A1_GA_IMP_VAL         4'h0
`define ISAID_A1_GA_5R_LSB          24
`define ISAID_A1_GA_5R_VAL          4'h0
`define ISAID_A1_RCONS_LSB          20
`define ISAID_A1_RCONS_VAL          4'h2
`define ISAID_A1_CPLX_LSB           16
`define ISAID_A1_CPLX_VAL           4'h1
`define ISAID_A1_SCONV_LSB          12
`define ISAID_A1_SCONV_VAL          4'h1
`define ISAID_A1_AA_IMP_LSB         8
`define ISAID_A1_AA_IMP_VAL         4'h0
`define ISAID_A1_AA_5R_LSB          4
`define ISAID_A1_AA_5R_VAL          4'h0
`define ISAID_A1_PERSIST_LSB        0
`define ISAID_A1_PERSIST_VAL        4'h2

// ----------------------------------------------------------------------------
// Second register field positions (low bit) and values
// ----------------------------------------------------------------------------
`define ISAID_A2_CPAC_LSB           24
`define ISAID_A2_CPAC_VAL           4'h1
`define ISAID_A2_AA_3R_LSB          12
`define ISAID_A2_AA_3R_VAL          4'h5
`define ISAID_A2_GA_3R_LSB          8
`define ISAID_A2_GA_3R_VAL          4'h1
`define ISAID_A2_RPREC_LSB          4
`define ISAID_A2_RPREC_VAL          4'h0
`define ISAID_A2_TWAIT_LSB          0
`define ISAID_A2_TWAIT_VAL          4'h2

`endif

// file: shared/isaid_pkg.sv
package isaid_pkg;

	// ------------------------------------------------------------------------
	// Privilege levels of the requester
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ISAID_USER_PRIVILEGE_LEVEL       = 2'h0,
		ISAID_KERNEL_PRIVILEGE_LEVEL     = 2'h1,
		ISAID_HYPERVISOR_PRIVILEGE_LEVEL = 2'h2,
		ISAID_MONITOR_PRIVILEGE_LEVEL    = 2'h3
	} isaid_level_t;

	// ------------------------------------------------------------------------
	// Read request from the core's system-register pipeline
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic         valid;
		logic [1:0]   op0;
		logic [2:0]   op1;
		logic [3:0]   crn;
		logic [3:0]   crm;
		logic [2:0]   op2;
		isaid_level_t level;
		logic         hyp_enabled;
		logic         hyp_trap_general_bit;
		logic         hyp_trap_id_group3_bit;
	} isaid_req_t;

	// ------------------------------------------------------------------------
	// Answer: either data or a trap
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic         valid;
		logic         hit;
		logic         trap;
		isaid_level_t trap_level;
		logic [5:0]   trap_class;
		logic [63:0]  data;
	} isaid_rsp_t;

endpackage

// file: logic/isaid_field.sv
`timescale 1ns/1ps

`include "isaid_regs.svh"

// Places one constant four-bit field at its position in a 64-bit word
module isaid_field #(
	parameter int          LSB = 0,   // Low bit of the field
	parameter logic [3:0]  VAL = 4'h0 // Field value
) (
	// Output
	output wire logic [63:0] word_o
);

	// ------------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------------
	if (LSB < 0 || LSB > 60 || (LSB % 4) != 0) begin : g_bad_lsb
		$error("isaid_field: LSB must be a multiple of 4 within 0..60");
	end

	// Shift the nibble into place; everything else reads zero
	assign word_o = {60'h0, VAL} << LSB;

endmodule // isaid_field

// file: logic/isaid_regs_top.sv
`timescale 1ns/1ps

`include "isaid_regs.svh"

module isaid_regs_top (
	// Clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rstn_i,
	// Request from the system-register pipeline
	input  wire isaid_pkg::isaid_req_t req_i,
	// Registered answer, one cycle after the request
	output      isaid_pkg::isaid_rsp_t rsp_o
);

	// ------------------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------------------
	logic rst_meta_q;  // First stage, read only by the second
	logic rstn_q;      // Released reset used by the block

	// Asynchronous assert, synchronous release
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_q <= 1'b0;
			rstn_q     <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rstn_q     <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------------------
	// Register images built from constant fields
	// ------------------------------------------------------------------------
	localparam int NF1 = 16; // Fields in the first register
	localparam int NF2 = 5;  // Fields in the second register

	localparam int         A1_LSB [NF1] = '{
		`ISAID_A1_WIDE_LS_LSB, `ISAID_A1_XSYNC_LSB, `ISAID_A1_INT8MM_LSB,
		`ISAID_A1_GHINT_LSB, `ISAID_A1_BFLOAT_LSB, `ISAID_A1_PRESTR_LSB,
		`ISAID_A1_SBAR_LSB, `ISAID_A1_RINT_LSB, `ISAID_A1_GA_IMP_LSB,
		`ISAID_A1_GA_5R_LSB, `ISAID_A1_RCONS_LSB, `ISAID_A1_CPLX_LSB,
		`ISAID_A1_SCONV_LSB, `ISAID_A1_AA_IMP_LSB, `ISAID_A1_AA_5R_LSB,
		`ISAID_A1_PERSIST_LSB};
	localparam logic [3:0] A1_VAL [NF1] = '{
		`ISAID_A1_WIDE_LS_VAL, `ISAID_A1_XSYNC_VAL, `ISAID_A1_INT8MM_VAL,
		`ISAID_A1_GHINT_VAL, `ISAID_A1_BFLOAT_VAL, `ISAID_A1_PRESTR_VAL,
		`ISAID_A1_SBAR_VAL, `ISAID_A1_RINT_VAL, `ISAID_A1_GA_IMP_VAL,
		`ISAID_A1_GA_5R_VAL, `ISAID_A1_RCONS_VAL, `ISAID_A1_CPLX_VAL,
		`ISAID_A1_SCONV_VAL, `ISAID_A1_AA_IMP_VAL, `ISAID_A1_AA_5R_VAL,
		`ISAID_A1_PERSIST_VAL};
	localparam int         A2_LSB [NF2] = '{
		`ISAID_A2_CPAC_LSB, `ISAID_A2_AA_3R_LSB, `ISAID_A2_GA_3R_LSB,
		`ISAID_A2_RPREC_LSB, `ISAID_A2_TWAIT_LSB};
	localparam logic [3:0] A2_VAL [NF2] = '{
		`ISAID_A2_CPAC_VAL, `ISAID_A2_AA_3R_VAL, `ISAID_A2_GA_3R_VAL,
		`ISAID_A2_RPREC_VAL, `ISAID_A2_TWAIT_VAL};

	logic [63:0] a1_part [NF1]; // Placed fields, first register
	logic [63:0] a2_part [NF2]; // Placed fields, second register
	logic [63:0] attr1_word;    // Full image of the first register
	logic [63:0] attr2_word;    // Full image of the second register

	// One placer per field of the first register
	for (genvar g = 0; g < NF1; g++) begin : g_a1
		isaid_field #(.LSB(A1_LSB[g]), .VAL(A1_VAL[g])) u_fld (
			.word_o (a1_part[g])
		);
	end

	// One placer per field of the second register
	for (genvar g = 0; g < NF2; g++) begin : g_a2
		isaid_field #(.LSB(A2_LSB[g]), .VAL(A2_VAL[g])) u_fld (
			.word_o (a2_part[g])
		);
	end

	// OR the fields together; unplaced bits stay zero
	always_comb begin
		attr1_word = 64'h0;
		attr2_word = 64'h0;
		for (int i = 0; i < NF1; i++) begin
			attr1_word = attr1_word | a1_part[i];
		end
		for (int i = 0; i < NF2; i++) begin
			attr2_word = attr2_word | a2_part[i];
		end
	end

	// ------------------------------------------------------------------------
	// Encoding decode
	// ------------------------------------------------------------------------
	logic enc_base; // op0/op1/CRn/CRm match the group
	logic sel1;     // First register selected
	logic sel2;     // Second register selected

	// Both registers share all encoding fields except op2
	assign enc_base = req_i.valid && req_i.op0 == `ISAID_OP0 && req_i.op1 == `ISAID_OP1
		&& req_i.crn == `ISAID_CRN && req_i.crm == `ISAID_CRM;
	assign sel1 = enc_base && req_i.op2 == `ISAID_OP2_ATTR1;
	assign sel2 = enc_base && req_i.op2 == `ISAID_OP2_ATTR2;

	// ------------------------------------------------------------------------
	// Privilege check
	// ------------------------------------------------------------------------
	logic                   trap_d;  // Access must trap
	isaid_pkg::isaid_level_t tlvl_d; // Level the trap is taken to

	// Trap routing by current level and hypervisor controls
	always_comb begin
		trap_d = 1'b0;
		tlvl_d = isaid_pkg::ISAID_KERNEL_PRIVILEGE_LEVEL;
		case (req_i.level)
			isaid_pkg::ISAID_USER_PRIVILEGE_LEVEL: begin
				// Always traps; general-trap bit steers it upward
				trap_d = 1'b1;
				if (req_i.hyp_enabled && req_i.hyp_trap_general_bit) begin
					tlvl_d = isaid_pkg::ISAID_HYPERVISOR_PRIVILEGE_LEVEL;
				end
			end
			isaid_pkg::ISAID_KERNEL_PRIVILEGE_LEVEL: begin
				// Group-3 identification trap to hypervisor
				if (req_i.hyp_enabled && req_i.hyp_trap_id_group3_bit) begin
					trap_d = 1'b1;
					tlvl_d = isaid_pkg::ISAID_HYPERVISOR_PRIVILEGE_LEVEL;
				end
			end
			default: begin
				// Hypervisor and monitor read directly
				trap_d = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Registered answer
	// ------------------------------------------------------------------------
	isaid_pkg::isaid_rsp_t rsp_q; // Answer register

	// Data only leaves when no trap, so privileged contents never leak
	always_ff @(posedge core_clk_i or negedge rstn_q) begin
		if (!rstn_q) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid      <= req_i.valid;
			rsp_q.hit        <= sel1 || sel2;
			rsp_q.trap       <= (sel1 || sel2) && trap_d;
			rsp_q.trap_level <= tlvl_d;
			rsp_q.trap_class <= ((sel1 || sel2) && trap_d) ? `ISAID_EC_SYSACC : 6'h0;
			if (sel1 && !trap_d) begin
				rsp_q.data <= attr1_word;
			end else if (sel2 && !trap_d) begin
				rsp_q.data <= attr2_word;
			end else begin
				rsp_q.data <= 64'h0;
			end
		end
	end

	assign rsp_o = rsp_q;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	user_trap_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		(sel1 || sel2) && req_i.level == isaid_pkg::ISAID_USER_PRIVILEGE_LEVEL
		|=> rsp_o.trap && rsp_o.trap_class == 6'h18 && rsp_o.data == 64'h0)
		else $error("user read did not trap");

	user_route_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		(sel1 || sel2) && req_i.level == isaid_pkg::ISAID_USER_PRIVILEGE_LEVEL
		&& !(req_i.hyp_enabled && req_i.hyp_trap_general_bit)
		|=> rsp_o.trap_level == isaid_pkg::ISAID_KERNEL_PRIVILEGE_LEVEL)
		else $error("user trap misrouted");

	kernel_trap_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		(sel1 || sel2) && req_i.level == isaid_pkg::ISAID_KERNEL_PRIVILEGE_LEVEL
		|=> rsp_o.trap == $past(req_i.hyp_enabled && req_i.hyp_trap_id_group3_bit))
		else $error("kernel trap decision wrong");

	high_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		sel2 && req_i.level[1] |=> !rsp_o.trap && rsp_o.data == 64'h0000_0000_0100_5102)
		else $error("high level read of second register wrong");

	attr1_val_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		sel1 && req_i.level == isaid_pkg::ISAID_MONITOR_PRIVILEGE_LEVEL
		|=> rsp_o.data == 64'h0111_1111_0021_1002)
		else $error("first register value wrong");

	reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		rsp_o.hit && !rsp_o.trap && !$past(sel1) |-> rsp_o.data[63:28] == 36'h0 && rsp_o.data[23:16] == 8'h00)
		else $error("reserved bits set");

	decode_hit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		req_i.valid && !(req_i.op0 == 2'h3 && req_i.op1 == 3'h0 && req_i.crn == 4'h0
		&& req_i.crm == 4'h6 && req_i.op2 inside {3'h1, 3'h2}) |=> !rsp_o.hit)
		else $error("wrong encoding decoded");

	miss_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_q)
		!rsp_o.hit |-> !rsp_o.trap && rsp_o.data == 64'h0)
		else $error("miss produced trap or data");

endmodule // isaid_regs_top

// file: tb/tb.sv
`timescale 1ns/1ps

`include "isaid_regs.svh"

module tb;

	// ------------------------------------------------------------------------
	// Clock, reset and ports
	// ------------------------------------------------------------------------
	logic                  core_clk = 1'b0; // Core clock, 8 ns period
	logic                  rst_n    = 1'b0; // Reset, active low
	isaid_pkg::isaid_req_t req;             // Request into the block
	isaid_pkg::isaid_rsp_t rsp;             // Registered answer
	isaid_pkg::isaid_rsp_t got;             // Answer captured by send
	int                    miscompares = 0; // Mismatches seen
	int                    checks      = 0; // Comparisons made

	// Field by field, high nibble first
	localparam logic [63:0] EXP_ATTR1 = {4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1,
		4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h2};
	// Reserved spans read as zero
	localparam logic [63:0] EXP_ATTR2 = {36'h0, 4'h1, 8'h00, 4'h5, 4'h1, 4'h0, 4'h2};

	always #4 core_clk = ~core_clk;

	isaid_regs_top u_isaid_regs_top (
		.core_clk_i         (core_clk),
		.rstn_i             (rst_n),
		.req_i              (req),
		.rsp_o              (rsp)
	);

	// ------------------------------------------------------------------------
	// Request building and expected answers
	// ------------------------------------------------------------------------
	// Matching encoding; ctl bits are hyp enable, general trap, group3 trap
	function automatic isaid_pkg::isaid_req_t mk(input logic [1:0] lv, input logic [2:0] op2,
		input logic [2:0] ctl);
		isaid_pkg::isaid_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.op0 = 2'h3;
		r.crm = 4'h6;
		r.op2 = op2;
		r.level = isaid_pkg::isaid_level_t'(lv);
		{r.hyp_enabled, r.hyp_trap_general_bit, r.hyp_trap_id_group3_bit} = ctl;
		return r;
	endfunction

	// Worked out from the access rules, independent of the design
	function automatic isaid_pkg::isaid_rsp_t exp_rsp(input isaid_pkg::isaid_req_t r);
		isaid_pkg::isaid_rsp_t e;
		e = '0;
		e.valid = r.valid;
		if (r.valid && r.op0 == 2'h3 && r.op1 == 3'h0 && r.crn == 4'h0 && r.crm == 4'h6 &&
			(r.op2 == 3'h1 || r.op2 == 3'h2)) begin
			e.hit = 1'b1;
			// User level always traps; kernel only under group3 control
			if (r.level == 2'h0) begin
				e.trap = 1'b1;
				e.trap_level = (r.hyp_enabled && r.hyp_trap_general_bit) ?
					isaid_pkg::ISAID_HYPERVISOR_PRIVILEGE_LEVEL :
					isaid_pkg::ISAID_KERNEL_PRIVILEGE_LEVEL;
			end else if (r.level == 2'h1 && r.hyp_enabled && r.hyp_trap_id_group3_bit) begin
				e.trap = 1'b1;
				e.trap_level = isaid_pkg::ISAID_HYPERVISOR_PRIVILEGE_LEVEL;
			end
			if (e.trap)
				e.trap_class = 6'h18;
			else
				e.data = (r.op2 == 3'h1) ? EXP_ATTR1 : EXP_ATTR2;
		end
		return e;
	endfunction

	// ------------------------------------------------------------------------
	// Compare tasks, one per kind of result
	// ------------------------------------------------------------------------
	// Trap routing fields only mean something when a trap is reported
	task automatic chk_rsp(input isaid_pkg::isaid_rsp_t g, input isaid_pkg::isaid_rsp_t e);
		logic bad;
		checks++;
		bad = (g.valid !== e.valid) || (g.hit !== e.hit) || (g.trap !== e.trap);
		bad = bad || (g.data !== e.data) || (g.trap_class !== e.trap_class);
		if (e.trap)
			bad = bad || (g.trap_level !== e.trap_level);
		if (bad) begin
			miscompares++;
			$display("[ERR] %0t answer got %h expected %h", $time, g, e);
		end
	endtask

	// Answer must be fully cleared while reset is asserted
	task automatic chk_idle(input isaid_pkg::isaid_rsp_t g);
		checks++;
		if (g !== '0) begin
			miscompares++;
			$display("[ERR] %0t answer not cleared in reset: %h", $time, g);
		end
	endtask

	// ------------------------------------------------------------------------
	// Access protocol: drive after the edge, answer one edge later
	// ------------------------------------------------------------------------
	// Valid is left up so calls run back to back every cycle
	task automatic send(input isaid_pkg::isaid_req_t r);
		req = r;
		@(posedge core_clk);
		#1;
		got = rsp;
	endtask

	task automatic rd(input isaid_pkg::isaid_req_t r);
		send(r);
		chk_rsp(got, exp_rsp(r));
	endtask

	// Internal reset copy needs two edges; first request at the third
	task automatic release_reset();
		rst_n = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		isaid_pkg::isaid_req_t r;
		req = '0;
		repeat (10) @(posedge core_clk);
		#1;
		chk_idle(rsp);
		release_reset();
		// Plain reads from the monitor level
		rd(mk(2'h3, 3'h1, 3'h0));
		rd(mk(2'h3, 3'h1, 3'h7));
		rd(mk(2'h3, 3'h2, 3'h0));
		// Every level against every trap control setting, both registers
		for (int lv = 0; lv < 4; lv++) begin
			for (int c = 0; c < 8; c++) begin
				for (int op = 1; op < 3; op++) begin
					rd(mk(lv[1:0], op[2:0], c[2:0]));
				end
			end
		end
		// One encoding field off at a time: no hit, no trap
		for (int i = 0; i < 6; i++) begin
			r = mk(2'h3, 3'h1, 3'h0);
			case (i)
				0: r.op0 = 2'h2;
				1: r.op1 = 3'h1;
				2: r.crn = 4'h1;
				3: r.crm = 4'h7;
				4: r.op2 = 3'h0;
				default: r.op2 = 3'h3;
			endcase
			rd(r);
		end
		// No request gives no answer
		r = '0;
		rd(r);
		// Reset in mid-run clears the answer at once
		rd(mk(2'h3, 3'h1, 3'h0));
		// Request dropped so no read straddles the internal release
		req = '0;
		rst_n = 1'b0;
		#1;
		chk_idle(rsp);
		repeat (2) @(posedge core_clk);
		#1;
		release_reset();
		rd(mk(2'h1, 3'h2, 3'h5));
		rd(mk(2'h0, 3'h1, 3'h6));
		conclude();
	end

	// Watchdog so a hang still reaches the verdict
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		$display("[ERR] %0t run did not finish in time", $time);
		conclude();
	end

endmodule // tb
